// [hdl/cbt_core_timing.sv]
// branch decode, instruction timing, timer tick and dual data pointers
// Summary of operation
// - external move lasts two plus stretch cycles
// - one instruction cycle is four clocks
// - instructions take one to nine cycles
// - byte count equals program fetches
// - timer tick every twelve, optionally four
// - absolute call/jump: two bytes, three cycles
// - long call, returns: four cycles
// - short and carry jumps: two bytes, three
// - jump bit set then clear it
// - bit-test jumps: three bytes, four cycles
// - indirect jump: one byte, three cycles
// - accumulator jumps: two bytes, three cycles
// - compare jumps: three bytes, four cycles
// - decrement jumps: register or direct forms
// - opcodes 00 and A5 are no-ops
// - two pointers at 82/83 and 84/85
// - select bit 0 picks active pointer
// - pointer instructions use selected pointer
// - select upper bits read zero
// - fixed bits ignore writes, read constant
`timescale 1ns/1ps
module cbt_core_timing (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic op_start,
    input wire logic [7:0] opcode,
    input wire logic [15:0] operand,
    input wire logic [7:0] rel_offset,
    input wire logic [15:0] next_pc,
    input wire logic [7:0] acc,
    input wire cbt_pkg::cbt_cond_type cond,
    input wire logic ptr_load,
    input wire logic [15:0] ptr_load_value,
    input wire logic ptr_inc,
    output logic busy,
    output logic done,
    output logic [1:0] instr_bytes,
    output logic [3:0] instr_cycles,
    output logic branch_taken,
    output logic [15:0] branch_target,
    output logic bit_clear,
    output logic [15:0] active_pointer,
    output logic timer_tick
);
    function automatic cbt_pkg::cbt_decode_type decode(input logic [7:0] op,
                                                       input logic [2:0] stretch);
        cbt_pkg::cbt_decode_type d;
        d = '{bytes: 2'd1, cycles: 4'd1, kind: cbt_pkg::KIND_PLAIN};
        if (op[4:0] == 5'h11)
            d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_ABS_CALL};
        else if (op[4:0] == 5'h01)
            d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_ABS_JUMP};
        else if (op[7:3] == 5'h1B)
            d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_DECJ};
        else if (op[7:3] == 5'h17 || op == 8'hB6 || op == 8'hB7 || op == 8'hB4 || op == 8'hB5)
            d = '{bytes: 2'd3, cycles: 4'd4, kind: cbt_pkg::KIND_CMPJ};
        else if (op == 8'hE0 || op == 8'hE2 || op == 8'hE3 || op == 8'hF0 || op == 8'hF2
                 || op == 8'hF3)
            d = '{bytes: 2'd1, cycles: cbt_pkg::MOVE_BASE_CYCLES + {1'b0, stretch},
                  kind: cbt_pkg::KIND_XMOVE};
        else begin
            case (op)
                8'h00, 8'hA5: d = '{bytes: 2'd1, cycles: 4'd1, kind: cbt_pkg::KIND_NOP};
                8'h12: d = '{bytes: 2'd3, cycles: 4'd4, kind: cbt_pkg::KIND_LONG_CALL};
                8'h22, 8'h32: d = '{bytes: 2'd1, cycles: 4'd4, kind: cbt_pkg::KIND_RETURN};
                8'h02: d = '{bytes: 2'd3, cycles: 4'd4, kind: cbt_pkg::KIND_LONG_JUMP};
                8'h80: d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_REL_JUMP};
                8'h40: d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_JC};
                8'h50: d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_JNC};
                8'h20: d = '{bytes: 2'd3, cycles: 4'd4, kind: cbt_pkg::KIND_JBIT1};
                8'h30: d = '{bytes: 2'd3, cycles: 4'd4, kind: cbt_pkg::KIND_JBIT0};
                8'h10: d = '{bytes: 2'd3, cycles: 4'd4, kind: cbt_pkg::KIND_JBIT1CLR};
                8'h73: d = '{bytes: 2'd1, cycles: 4'd3, kind: cbt_pkg::KIND_JMP_IND};
                8'h60: d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_JACC0};
                8'h70: d = '{bytes: 2'd2, cycles: 4'd3, kind: cbt_pkg::KIND_JACCNZ};
                8'hD5: d = '{bytes: 2'd3, cycles: 4'd4, kind: cbt_pkg::KIND_DECJ};
                default: d = '{bytes: 2'd1, cycles: 4'd1, kind: cbt_pkg::KIND_PLAIN};
            endcase
        end
        return d;
    endfunction

    // register state
    logic [7:0] stack_pointer_q;
    logic [15:0] ptr0_q;
    logic [15:0] ptr1_q;
    logic sel_q;
    logic [5:0] clock_speed_q;
    logic [7:0] sfr_rdata_q;
    cbt_pkg::cbt_state_type state_q;
    logic [1:0] phase_q;
    logic [3:0] remain_q;
    logic busy_q;
    logic done_q;
    logic [1:0] bytes_q;
    logic [3:0] cycles_q;
    logic taken_q;
    logic [15:0] target_q;
    logic clear_q;
    logic [3:0] presc_q;
    logic tick_q;

    // decoding and selection
    wire logic [2:0] stretch = clock_speed_q[cbt_pkg::STRETCH_MSB:cbt_pkg::STRETCH_LSB];
    wire cbt_pkg::cbt_decode_type dec = decode(opcode, stretch);
    wire logic start_ok = op_start && (state_q == cbt_pkg::ST_IDLE);
    wire logic [15:0] act_ptr = sel_q ? ptr1_q : ptr0_q;
    wire logic [15:0] rel_target = next_pc + {{8{rel_offset[7]}}, rel_offset};
    wire logic [15:0] abs_target = {next_pc[15:11], opcode[7:5], operand[7:0]};
    wire logic [15:0] ind_target = act_ptr + {8'h00, acc};
    wire logic icycle_end = (phase_q == cbt_pkg::CLKS_PER_ICYCLE_M1);
    wire logic last_clk = (state_q == cbt_pkg::ST_EXEC) && icycle_end && (remain_q == 4'h0);
    wire logic wr_sp = sfr_wr && (sfr_addr == cbt_pkg::ADDR_STACK_POINTER);
    wire logic wr_p0l = sfr_wr && (sfr_addr == cbt_pkg::ADDR_POINTER0_LOW);
    wire logic wr_p0h = sfr_wr && (sfr_addr == cbt_pkg::ADDR_POINTER0_HIGH);
    wire logic wr_p1l = sfr_wr && (sfr_addr == cbt_pkg::ADDR_POINTER1_LOW);
    wire logic wr_p1h = sfr_wr && (sfr_addr == cbt_pkg::ADDR_POINTER1_HIGH);
    wire logic wr_sel = sfr_wr && (sfr_addr == cbt_pkg::ADDR_POINTER_SELECT);
    wire logic wr_cks = sfr_wr && (sfr_addr == cbt_pkg::ADDR_CLOCK_SPEED_CONTROL);
    wire logic [15:0] ptr_next = ptr_load ? ptr_load_value : act_ptr + 16'h0001;
    wire logic ptr_upd = ptr_load || ptr_inc;
    wire logic [3:0] tick_lim = clock_speed_q[cbt_pkg::TICK_FAST_BIT]
                                ? cbt_pkg::TICK_FAST_M1 : cbt_pkg::TICK_SLOW_M1;

    logic taken_d;
    logic [15:0] target_d;
    always_comb begin
        taken_d = 1'b0;
        target_d = rel_target;
        case (dec.kind)
            cbt_pkg::KIND_ABS_JUMP, cbt_pkg::KIND_ABS_CALL: begin
                taken_d = 1'b1;
                target_d = abs_target;
            end
            cbt_pkg::KIND_LONG_CALL, cbt_pkg::KIND_LONG_JUMP: begin
                taken_d = 1'b1;
                target_d = operand;
            end
            cbt_pkg::KIND_JMP_IND: begin
                taken_d = 1'b1;
                target_d = ind_target;
            end
            cbt_pkg::KIND_REL_JUMP: taken_d = 1'b1;
            cbt_pkg::KIND_JC: taken_d = cond.carry;
            cbt_pkg::KIND_JNC: taken_d = !cond.carry;
            cbt_pkg::KIND_JBIT1,
            cbt_pkg::KIND_JBIT1CLR: taken_d = cond.bit_val;
            cbt_pkg::KIND_JBIT0: taken_d = !cond.bit_val;
            cbt_pkg::KIND_JACC0: taken_d = cond.acc_zero;
            cbt_pkg::KIND_JACCNZ: taken_d = !cond.acc_zero;
            cbt_pkg::KIND_CMPJ: taken_d = cond.cmp_ne;
            cbt_pkg::KIND_DECJ: taken_d = cond.dec_nz;
            default: taken_d = 1'b0;
        endcase
    end

    logic [7:0] rdata_d;
    always_comb begin
        case (sfr_addr)
            cbt_pkg::ADDR_STACK_POINTER: rdata_d = stack_pointer_q;
            cbt_pkg::ADDR_POINTER0_LOW: rdata_d = ptr0_q[7:0];
            cbt_pkg::ADDR_POINTER0_HIGH: rdata_d = ptr0_q[15:8];
            cbt_pkg::ADDR_POINTER1_LOW: rdata_d = ptr1_q[7:0];
            cbt_pkg::ADDR_POINTER1_HIGH: rdata_d = ptr1_q[15:8];
            cbt_pkg::ADDR_POINTER_SELECT: rdata_d = {7'h00, sel_q};
            cbt_pkg::ADDR_CLOCK_SPEED_CONTROL: rdata_d = {2'h0, clock_speed_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // register file; pointer instructions take priority over bus writes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stack_pointer_q <= cbt_pkg::STACK_POINTER_RESET;
            sel_q <= 1'b0;
            clock_speed_q <= cbt_pkg::CLOCK_SPEED_RESET;
            sfr_rdata_q <= 8'h00;
        end else begin
            if (wr_sp) stack_pointer_q <= sfr_wdata;
            if (wr_sel) sel_q <= sfr_wdata[cbt_pkg::SEL_BIT];
            if (wr_cks) clock_speed_q <= sfr_wdata[5:0] & cbt_pkg::CLOCK_SPEED_USED_MASK;
            if (sfr_rd) sfr_rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr0_q <= cbt_pkg::POINTER_RESET;
            ptr1_q <= cbt_pkg::POINTER_RESET;
        end else if (ptr_upd) begin
            if (sel_q) ptr1_q <= ptr_next;
            else ptr0_q <= ptr_next;
        end else begin
            if (wr_p0l) ptr0_q[7:0] <= sfr_wdata;
            if (wr_p0h) ptr0_q[15:8] <= sfr_wdata;
            if (wr_p1l) ptr1_q[7:0] <= sfr_wdata;
            if (wr_p1h) ptr1_q[15:8] <= sfr_wdata;
        end
    end

    // execution sequencer: four clocks per instruction cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= cbt_pkg::ST_IDLE;
            phase_q <= 2'h0;
            remain_q <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= last_clk;
            case (state_q)
                cbt_pkg::ST_IDLE: if (start_ok) begin
                    state_q <= cbt_pkg::ST_EXEC;
                    phase_q <= 2'h0;
                    remain_q <= dec.cycles - 4'h1;
                    busy_q <= 1'b1;
                end
                cbt_pkg::ST_EXEC: begin
                    phase_q <= phase_q + 2'h1;
                    if (icycle_end && remain_q != 4'h0) remain_q <= remain_q - 4'h1;
                    if (last_clk) begin
                        state_q <= cbt_pkg::ST_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: state_q <= cbt_pkg::ST_IDLE;
            endcase
        end
    end

    // decode results are captured at start so operands may change meanwhile
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bytes_q <= 2'h0;
            cycles_q <= 4'h0;
            taken_q <= 1'b0;
            target_q <= 16'h0000;
            clear_q <= 1'b0;
        end else if (start_ok) begin
            bytes_q <= dec.bytes;
            cycles_q <= dec.cycles;
            taken_q <= taken_d;
            target_q <= target_d;
            clear_q <= (dec.kind == cbt_pkg::KIND_JBIT1CLR) && cond.bit_val;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (presc_q >= tick_lim);
            presc_q <= (presc_q >= tick_lim) ? 4'h0 : presc_q + 4'h1;
        end
    end

    assign sfr_rdata = sfr_rdata_q;
    assign busy = busy_q;
    assign done = done_q;
    assign instr_bytes = bytes_q;
    assign instr_cycles = cycles_q;
    assign branch_taken = taken_q;
    assign branch_target = target_q;
    assign bit_clear = clear_q;
    assign active_pointer = sel_q ? ptr1_q : ptr0_q;
    assign timer_tick = tick_q;

    // consecutive busy clocks, so long runs are checked without a long repetition
    logic [5:0] busy_run_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_run_q <= 6'h00;
        end else begin
            busy_run_q <= busy_q ? busy_run_q + 6'h01 : 6'h00;
        end
    end

    AST_FOUR_CLK_CYCLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_ok && opcode == 8'h00 |=> busy[*4] ##1 (!busy && done))
        else $error("nop did not take four clocks");
    AST_MOVE_STRETCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_ok && opcode == 8'hE0 |=> cycles_q == 4'h2 + {1'b0, $past(stretch)})
        else $error("external move cycles wrong");
    AST_ABSOLUTE_CALL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_ok && opcode[4:0] == 5'h11 |=> bytes_q == 2'd2 && cycles_q == 4'd3 && taken_q)
        else $error("absolute call decode wrong");
    AST_LONG_CALL_LEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_ok && opcode == 8'h12 |-> ##17 (done && !busy && busy_run_q == 6'h10))
        else $error("long call not sixteen clocks");
    AST_JBC_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_ok && opcode == 8'h10 |=> bit_clear == $past(cond.bit_val) && taken_q == bit_clear)
        else $error("bit clear jump wrong");
    AST_REL_TARGET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_ok && opcode == 8'h80
        |=> branch_target == $past(next_pc) + {{8{$past(rel_offset[7])}}, $past(rel_offset)})
        else $error("relative target wrong");
    AST_SEL_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sfr_rd && sfr_addr == cbt_pkg::ADDR_POINTER_SELECT |=> sfr_rdata[7:1] == 7'h00)
        else $error("select upper bits not zero");
    AST_PTR_INC: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ptr_inc && !ptr_load && !wr_sel |=> active_pointer == $past(active_pointer) + 16'h0001)
        else $error("active pointer not incremented");
    AST_TICK_SLOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(timer_tick) && !clock_speed_q[cbt_pkg::TICK_FAST_BIT] && !wr_cks
        |=> !timer_tick[*8])
        else $error("slow tick too early");
endmodule

// [hdl/cbt_pkg.sv]
// shared constants and types for the branch timing and dual pointer core
package cbt_pkg;
    localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
    localparam logic [7:0] ADDR_POINTER0_LOW = 8'h82;
    localparam logic [7:0] ADDR_POINTER0_HIGH = 8'h83;
    localparam logic [7:0] ADDR_POINTER1_LOW = 8'h84;
    localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h85;
    localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
    localparam logic [7:0] ADDR_CLOCK_SPEED_CONTROL = 8'h8E;
    localparam int SEL_BIT = 0;
    localparam int STRETCH_LSB = 0;
    localparam int STRETCH_MSB = 2;
    localparam int TICK_FAST_BIT = 3;
    localparam logic [5:0] CLOCK_SPEED_USED_MASK = 6'h3F;
    localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [5:0] CLOCK_SPEED_RESET = 6'h01;
    localparam logic [1:0] CLKS_PER_ICYCLE_M1 = 2'h3;
    localparam logic [3:0] TICK_SLOW_M1 = 4'hB;
    localparam logic [3:0] TICK_FAST_M1 = 4'h3;
    localparam logic [3:0] MOVE_BASE_CYCLES = 4'h2;

    typedef enum logic [4:0] {
        KIND_PLAIN, KIND_NOP, KIND_ABS_JUMP, KIND_ABS_CALL, KIND_LONG_CALL,
        KIND_RETURN, KIND_LONG_JUMP, KIND_REL_JUMP, KIND_JC, KIND_JNC,
        KIND_JBIT1, KIND_JBIT0, KIND_JBIT1CLR, KIND_JMP_IND, KIND_JACC0, KIND_JACCNZ,
        KIND_CMPJ, KIND_DECJ, KIND_XMOVE
    } cbt_kind_type;

    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
        cbt_kind_type kind;
    } cbt_decode_type;

    typedef struct packed {
        logic carry;
        logic acc_zero;
        logic bit_val;
        logic cmp_ne;
        logic dec_nz;
    } cbt_cond_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } cbt_state_type;
endpackage

// [verif/cpu_branch_timing_dual_pointer_tb.sv]
// self-checking bench for the branch timing and dual pointer core
`timescale 1ns/1ps
module cpu_branch_timing_dual_pointer_tb;
    typedef struct {
        logic [1:0] nb;
        logic [3:0] nc;
        logic tk;
        logic [15:0] tg;
        logic bc;
        int t0;
    } cbt_exp_type;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, opcode = 8'h00, rel_offset = 8'h00;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, op_start = 1'b0, ptr_load = 1'b0, ptr_inc = 1'b0;
    logic [15:0] operand = 16'h0000, next_pc = 16'h0000, ptr_load_value = 16'h0000;
    logic [7:0] acc = 8'h00;
    cbt_pkg::cbt_cond_type cond = '0;
    logic [7:0] sfr_rdata;
    logic busy, done, branch_taken, bit_clear, timer_tick;
    logic [1:0] instr_bytes;
    logic [3:0] instr_cycles;
    logic [15:0] branch_target, active_pointer;
    logic [15:0] p_exp = 16'h0000;
    logic [2:0] stretch = 3'h1;
    logic [31:0] seed = 32'd24199;
    logic [7:0] move_ops [6] = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    cbt_exp_type exp_q [$];
    cbt_exp_type mon_e;
    int cyc = 0;
    int n_mismatch = 0;
    int comparisons = 0;

    cbt_core_timing u_cbt_core_timing (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .op_start(op_start), .opcode(opcode), .operand(operand),
        .rel_offset(rel_offset), .next_pc(next_pc), .acc(acc), .cond(cond),
        .ptr_load(ptr_load), .ptr_load_value(ptr_load_value), .ptr_inc(ptr_inc),
        .busy(busy), .done(done), .instr_bytes(instr_bytes), .instr_cycles(instr_cycles),
        .branch_taken(branch_taken), .branch_target(branch_target), .bit_clear(bit_clear),
        .active_pointer(active_pointer), .timer_tick(timer_tick));

    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) cyc <= cyc + 1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    // strobes drop for a cycle so back-to-back calls never re-assign in one step
    // callers only write assigned addresses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        step();
        sfr_wr = 1'b0;
        step();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        sfr_addr = a;
        sfr_rd = 1'b1;
        step();
        sfr_rd = 1'b0;
        check(32'(sfr_rdata), 32'(want));
        step();
    endtask

    function automatic cbt_exp_type mk(input int b, input int c, input logic t,
                                       input logic [15:0] g, input logic bc);
        cbt_exp_type e;
        e = '{b[1:0], c[3:0], t, g, bc, cyc};
        return e;
    endfunction

    // taken flag of x marks returns, whose target comes from the stack
    function automatic cbt_exp_type predict(input logic [7:0] op);
        logic [15:0] rel;
        rel = next_pc + {{8{rel_offset[7]}}, rel_offset};
        casez (op)
            8'h?1: return mk(2, 3, 1'b1, {next_pc[15:11], op[7:5], operand[7:0]},
                             1'b0);
            8'h12, 8'h02: return mk(3, 4, 1'b1, operand, 1'b0);
            8'h22, 8'h32: return mk(1, 4, 1'bx, 16'h0000, 1'b0);
            8'h80: return mk(2, 3, 1'b1, rel, 1'b0);
            8'h40: return mk(2, 3, cond.carry, rel, 1'b0);
            8'h50: return mk(2, 3, !cond.carry, rel, 1'b0);
            8'h20: return mk(3, 4, cond.bit_val, rel, 1'b0);
            8'h30: return mk(3, 4, !cond.bit_val, rel, 1'b0);
            8'h10: return mk(3, 4, cond.bit_val, rel, cond.bit_val);
            8'h73: return mk(1, 3, 1'b1, {8'h00, acc} + p_exp, 1'b0);
            8'h60, 8'h70: return mk(2, 3, cond.acc_zero ^ op[4], rel, 1'b0);
            8'b1011_01??, 8'b1011_1???: return mk(3, 4, cond.cmp_ne, rel, 1'b0);
            8'b1101_1???: return mk(2, 3, cond.dec_nz, rel, 1'b0);
            8'hD5: return mk(3, 4, cond.dec_nz, rel, 1'b0);
            8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
                return mk(1, 2 + stretch, 1'b0, 16'h0000, 1'b0);
            default: return mk(1, 1, 1'b0, 16'h0000, 1'b0);
        endcase
    endfunction

    // poke retries a start while busy; a refused start must not add a completion
    task automatic exec(input logic [7:0] op, input bit poke);
        logic [31:0] r;
        int k;
        r = rnd();
        opcode = op;
        operand = r[15:0];
        rel_offset = r[23:16];
        r = rnd();
        next_pc = r[15:0];
        acc = (r[19:16] == 4'h0) ? 8'h00 : r[27:20];
        cond = cbt_pkg::cbt_cond_type'(r[31:27]);
        cond.acc_zero = (acc == 8'h00);
        exp_q.push_back(predict(op));
        op_start = 1'b1;
        step();
        op_start = 1'b0;
        if (poke) begin
            step();
            opcode = 8'h00;
            op_start = 1'b1;
            step();
            op_start = 1'b0;
        end
        k = 0;
        while (done !== 1'b1) begin
            if (k == 100) begin
                n_mismatch++;
                summarize();
            end
            step();
            k++;
        end
    endtask

    task automatic tick_period(input int want);
        int n;
        n = 0;
        while (timer_tick !== 1'b1 && n < 50) begin
            step();
            n++;
        end
        if (n == 50) begin
            n_mismatch++;
            summarize();
        end
        n = 0;
        do begin
            step();
            n++;
        end while (timer_tick !== 1'b1 && n < 50);
        check(32'(n), 32'(want));
        if (n == 50) summarize();
    endtask

    always @(posedge ref_clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                mon_e = exp_q.pop_front();
                check(32'(instr_bytes), 32'(mon_e.nb));
                check(32'(instr_cycles), 32'(mon_e.nc));
                check(32'(cyc - mon_e.t0), 32'(4 * mon_e.nc + 1));
                check(32'(busy), 32'h0);
                check(32'(bit_clear), 32'(mon_e.bc));
                if (mon_e.tk !== 1'bx) check(32'(branch_taken), 32'(mon_e.tk));
                if (mon_e.tk === 1'b1) check(32'(branch_target), 32'(mon_e.tg));
            end
        end
    end

    initial begin
        logic [31:0] r;
        repeat (4) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        rd(8'h81, 8'h07);
        for (int a = 8'h82; a <= 8'h86; a++) rd(a[7:0], 8'h00);
        rd(8'h8E, 8'h01);
        rd(8'h80, 8'h00);
        wr(8'h86, 8'hFF);
        rd(8'h86, 8'h01);
        wr(8'h86, 8'h00);
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        wr(8'h84, 8'h78);
        wr(8'h85, 8'h56);
        check(32'(active_pointer), 32'h1234);
        wr(8'h86, 8'h01);
        check(32'(active_pointer), 32'h5678);
        rd(8'h84, 8'h78);
        r = rnd();
        ptr_load_value = r[15:0];
        ptr_load = 1'b1;
        step();
        ptr_load = 1'b0;
        step();
        check(32'(active_pointer), 32'(r[15:0]));
        rd(8'h85, r[15:8]);
        wr(8'h86, 8'h00);
        ptr_inc = 1'b1;
        step();
        ptr_inc = 1'b0;
        step();
        check(32'(active_pointer), 32'h1235);
        rd(8'h82, 8'h35);
        p_exp = 16'h1235;
        for (int i = 0; i < 256; i++) exec(i[7:0], (i % 16) == 5);
        for (int s = 0; s < 8; s++) begin
            wr(8'h8E, {5'h00, s[2:0]});
            stretch = s[2:0];
            exec(move_ops[s % 6], 1'b0);
        end
        tick_period(12);
        wr(8'h8E, 8'hFF);
        rd(8'h8E, 8'h3F);
        tick_period(4);
        repeat (3) step();
        check(32'(exp_q.size()), 32'h0);
        summarize();
    end
endmodule
